//--- core/tmh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_timer (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, low
   input wire logic timer_output_pin_in, // pin level, code zero source
   input wire logic [tmh_pkg::NUM_SRC-1:0] clk_src, // source levels by code
   input wire logic [15:0] upper_count, // other half count, used when linked
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   output logic timer_output_pin, // timer output pin
   output logic timer_irq // module interrupt
);

   tmh_pkg::tmh_state_s_t r, n;
   logic src_sel, tick, hit0, hit1, en, link, wr_go, rd_go;
   logic [15:0] cmp0, cmp1, ev, clr, set;
   logic [31:0] wmask, rd;
   logic [4:0] csel;
   logic [tmh_pkg::NUM_SRC-1:0] src;

   // ----------------------------------------
   // clock source
   // ----------------------------------------
   // the bus-clock /4 source comes from our own divider, not the input
   genvar gi;
   generate
      for (gi = 0; gi < tmh_pkg::NUM_SRC; gi++) begin : g_src
         if (gi == 0) begin : g_pin
            assign src[gi] = timer_output_pin_in;
         end else if (gi == 15) begin : g_hclk
            assign src[gi] = r.hdiv[1];
         end else begin : g_ext
            assign src[gi] = clk_src[gi];
         end
      end
   endgenerate

   assign csel = r.control[tmh_pkg::CLK_LSB +: 5];
   assign src_sel = (csel <= tmh_pkg::CLK_LAST) ? src[csel] : 1'b0;
   assign tick = src_sel & ~r.src_prev;
   assign en = r.control[tmh_pkg::EN_POS] | r.control[tmh_pkg::CONV_POS];
   assign link = r.control[tmh_pkg::LINK_POS];
   assign cmp0 = r.cmp[15:0];
   assign cmp1 = r.cmp[31:16];
   // linked mode: a compare needs the low half to match and upper_count to be zero; upper half counts carries outside
   assign hit0 = (r.count == cmp0) && (!link || upper_count == 16'h0000);
   assign hit1 = (r.count == cmp1) && (!link || upper_count == 16'h0000);

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr_go = r.have_aw && r.have_w && !r.bvalid;
   assign rd_go = s_axi_arvalid && !r.rvalid;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

   always_comb begin
      rd = 32'h0000_0000;
      unique case (s_axi_araddr)
         tmh_pkg::ADDR_CONTROL: rd = r.control;
         tmh_pkg::ADDR_CMP_A: rd = r.cmp;
         tmh_pkg::ADDR_COUNT: rd = {16'h0000, r.count};
         tmh_pkg::ADDR_INT_ENABLE: rd = {16'h0000, r.timer_interrupt_enable};
         tmh_pkg::ADDR_INT_STATUS: rd = {16'h0000, r.status};
         default: rd = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = r;
      ev = 16'h0000;
      clr = 16'h0000;
      set = 16'h0000;
      n.src_prev = src_sel;
      n.hdiv = r.hdiv + 2'h1;

      // counter and functions
      if (r.control[tmh_pkg::CLR_POS]) begin
         n.count = 16'h0000;
         n.state = tmh_pkg::ST_IDLE;
         n.tout = 1'b0;
      end else if (!en) begin
         n.state = tmh_pkg::ST_IDLE;
      end else if (tick && r.state != tmh_pkg::ST_STOP) begin
         n.state = tmh_pkg::ST_RUN;
         n.count = r.count + 16'h0001;
         if (r.control[tmh_pkg::FN_LSB +: 3] != 3'(tmh_pkg::FN_PERIODIC))
            n.tout = r.tout;
         else
            n.tout = 1'b0;
         unique case (r.control[tmh_pkg::FN_LSB +: 3])
            3'(tmh_pkg::FN_ONCE): begin
               if (hit0) begin
                  n.tout = ~r.tout;
                  n.count = r.count;
                  n.state = tmh_pkg::ST_STOP;
               end
            end
            3'(tmh_pkg::FN_PERIODIC): begin
               if (hit0) begin
                  n.tout = 1'b1;
                  n.count = 16'h0000;
               end
            end
            3'(tmh_pkg::FN_PULSE_ONCE), 3'(tmh_pkg::FN_PULSE_REPEAT): begin
               if (hit0)
                  n.tout = 1'b1;
               if (hit1) begin
                  n.tout = 1'b0;
                  if (r.control[tmh_pkg::FN_LSB]) begin
                     n.count = 16'h0000;
                  end else begin
                     n.count = r.count;
                     n.state = tmh_pkg::ST_STOP;
                  end
               end
            end
            default: ;
         endcase
         ev[tmh_pkg::EVT0_BIT] = hit0 & r.control[tmh_pkg::IE0_POS];
         ev[tmh_pkg::EVT1_BIT] = hit1 & r.control[tmh_pkg::IE1_POS];
      end

      // write channel capture
      if (s_axi_awvalid && !r.have_aw) begin
         n.have_aw = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.have_w) begin
         n.have_w = 1'b1;
         n.wdata = s_axi_wdata & wmask;
      end
      if (wr_go) begin
         n.have_aw = 1'b0;
         n.have_w = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = 2'b00;
         unique case (r.awaddr)
            tmh_pkg::ADDR_CONTROL:
               n.control = r.wdata & tmh_pkg::CONTROL_MASK;
            tmh_pkg::ADDR_CMP_A: n.cmp = r.wdata;
            tmh_pkg::ADDR_INT_ENABLE: n.timer_interrupt_enable = r.wdata[15:0];
            tmh_pkg::ADDR_INT_STATUS: set = r.wdata[15:0];
            tmh_pkg::ADDR_INT_CLEAR: clr = r.wdata[15:0];
            tmh_pkg::ADDR_INT_SET: set = r.wdata[15:0];
            tmh_pkg::ADDR_COUNT: ;
            default: n.bresp = 2'b10;
         endcase
      end
      if (r.bvalid && s_axi_bready)
         n.bvalid = 1'b0;

      // read channel
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rdata = rd;
         n.rresp = (s_axi_araddr == tmh_pkg::ADDR_CONTROL
                    || s_axi_araddr == tmh_pkg::ADDR_CMP_A
                    || s_axi_araddr == tmh_pkg::ADDR_COUNT
                    || s_axi_araddr[11:4] == 8'h20) ? 2'b00 : 2'b10;
      end else if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end

      // events win over a simultaneous clear
      n.status = (r.status & ~clr) | ev | set;
      n.irq = |(n.status & r.timer_interrupt_enable);
      n.pin_o = r.control[tmh_pkg::PE_POS]
                ? (n.tout ^ r.control[tmh_pkg::POL_POS])
                : r.control[tmh_pkg::POL_POS];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.control <= tmh_pkg::CONTROL_RESET;
         r.status <= tmh_pkg::INT_RESET;
         r.timer_interrupt_enable <= tmh_pkg::INT_RESET;
         r.state <= tmh_pkg::ST_IDLE;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = !r.have_aw;
   assign s_axi_wready = !r.have_w;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign timer_output_pin = r.pin_o;
   assign timer_irq = r.irq;

endmodule : tmh_timer
`default_nettype wire

//--- core/tmh_pkg.sv
package tmh_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] ADDR_CONTROL = 12'h03c;
   localparam logic [11:0] ADDR_CMP_A = 12'h034;
   localparam logic [11:0] ADDR_COUNT = 12'h030;
   localparam logic [11:0] ADDR_INT_ENABLE = 12'h200;
   localparam logic [11:0] ADDR_INT_STATUS = 12'h204;
   localparam logic [11:0] ADDR_INT_CLEAR = 12'h208;
   localparam logic [11:0] ADDR_INT_SET = 12'h20c;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int EN_POS = 0;
   localparam int CLK_LSB = 1;
   localparam int FN_LSB = 6;
   localparam int IE0_POS = 9;
   localparam int IE1_POS = 10;
   localparam int CLR_POS = 11;
   localparam int POL_POS = 12;
   localparam int PE_POS = 13;
   localparam int CONV_POS = 15;
   localparam int LINK_POS = 31;
   localparam logic [31:0] CONTROL_MASK = 32'h8000_bfff;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [15:0] INT_RESET = 16'h0000;

   // status bit of this half: A3 compare0 / compare1
   localparam int EVT0_BIT = 6;
   localparam int EVT1_BIT = 14;

   // clock select codes
   localparam logic [4:0] CLK_PIN = 5'h00;
   localparam logic [4:0] CLK_LAST = 5'h10;
   localparam int NUM_SRC = 17;

   // bus-clock / 4 divider
   localparam logic [1:0] HCLK_DIV = 2'h3;
   localparam logic [4:0] CLK_HCLK4 = 5'h0f;

   typedef enum logic [2:0] {
      FN_ONCE = 3'h0,
      FN_PERIODIC = 3'h1,
      FN_PULSE_ONCE = 3'h2,
      FN_PULSE_REPEAT = 3'h3,
      FN_FREE = 3'h4
   } tmh_fn_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_STOP = 3'b100
   } tmh_state_t;

   typedef struct packed {
      logic [31:0] control;
      logic [31:0] cmp;
      logic [15:0] count;
      logic [15:0] timer_interrupt_enable;
      logic [15:0] status;
      tmh_state_t state;
      logic tout;
      logic src_prev;
      logic [1:0] hdiv;
      logic pin_o;
      logic irq;
      logic bvalid;
      logic rvalid;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic have_aw;
      logic have_w;
      logic [11:0] awaddr;
      logic [31:0] wdata;
   } tmh_state_s_t;

endpackage : tmh_pkg

//--- verif/tmh_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_chk (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic [11:0] s_axi_awaddr, // aw addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // w data
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic [11:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic timer_output_pin, // pin
   input wire logic timer_irq // irq
);
   // ---
   // write shadow
   // ---
   logic [11:0] wa_r, ra_r;
   logic [31:0] wd_r, ctl_r, ien_r;
   logic [2:0] age_r;
   // age gives pin and irq time to follow a register write
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
      if (!aresetn) begin
         ctl_r <= 32'h0;
         ien_r <= 32'h0;
         age_r <= 3'h0;
      end else if (s_axi_bvalid) begin
         age_r <= 3'h0;
         if (wa_r == tmh_pkg::ADDR_CONTROL) ctl_r <= wd_r;
         if (wa_r == tmh_pkg::ADDR_INT_ENABLE) ien_r <= wd_r;
      end else if (age_r != 3'h7) begin
         age_r <= age_r + 3'h1;
      end
   end
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_event_width: assert property (
      s_axi_rvalid && ra_r[11:4] == 8'h20 |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper event bits set");
   a_unmapped_err: assert property (s_axi_rvalid && ra_r == 12'h100 |-> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   a_hold_zero: assert property (
      s_axi_rvalid && ra_r == tmh_pkg::ADDR_COUNT && ctl_r[11] |-> s_axi_rdata[15:0] == 16'h0)
      else $error("count not held");
   a_pin_idle: assert property (age_r == 3'h7 && !ctl_r[13] |-> timer_output_pin == ctl_r[12])
      else $error("idle pin level wrong");
   a_irq_mask: assert property (age_r == 3'h7 && ien_r[15:0] == 16'h0 |-> !timer_irq)
      else $error("irq while masked");
endmodule : tmh_chk
bind tmh_timer tmh_chk i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .timer_output_pin, .timer_irq);
`default_nettype wire

//--- verif/tmh_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_timer_tb_top;
   // ---
   // stimulus
   // ---
   localparam logic [11:0] CT = tmh_pkg::ADDR_CONTROL;
   localparam logic [11:0] CN = tmh_pkg::ADDR_COUNT;
   localparam logic [11:0] ST = tmh_pkg::ADDR_INT_STATUS;
   localparam logic [11:0] CL = tmh_pkg::ADDR_INT_CLEAR;
   localparam logic [11:0] SE = tmh_pkg::ADDR_INT_SET;
   logic aclk = 1'h0, aresetn = 1'h0, timer_output_pin_in = 1'h0;
   logic [16:0] clk_src = 17'h0;
   logic [15:0] upper_count = 16'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   // answers are always accepted at once
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic timer_output_pin, timer_irq;
   int fails = 0;
   int checked = 0;
   tmh_timer i_dut (.*);
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic test_done();
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] rs = 2'h0);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      // count is one half wide; unmapped data is don't-care
      chk({s_axi_rresp, s_axi_rdata & (a == CN ? 32'hffff : rs != 0 ? 32'h0 : 32'hffffffff)},
         {rs, e});
   endtask : rc
   task automatic tick(input int c, input int n);
      logic [16:0] v;
      v = (c > 16) ? 17'h1ffff : 17'h1 << c;
      repeat (n) begin
         @(posedge aclk);
         clk_src <= v;
         timer_output_pin_in <= v[0];
         repeat (2) @(posedge aclk);
         clk_src <= 17'h0;
         timer_output_pin_in <= 1'h0;
         repeat (2) @(posedge aclk);
      end
   endtask : tick
   initial begin
      #100000;
      fails++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      rc(tmh_pkg::ADDR_INT_ENABLE, 32'h0);
      rc(ST, 32'h0);
      rc(12'h100, 32'h0, 2'h2);
      wr(CT, 32'h102);
      tick(1, 3);
      rc(CN, 32'h0);
      for (int c = 0; c < 18; c++) begin
         if (c == 15) continue;
         wr(CT, 32'h901 | 32'(c << 1));
         tick(c, 2);
         rc(CN, 32'h0);
         wr(CT, 32'h101 | 32'(c << 1));
         tick(c, 3);
         rc(CN, (c > 16) ? 32'h0 : 32'h3);
      end
      wr(tmh_pkg::ADDR_CMP_A, 32'h0005_0003);
      wr(CT, 32'h2a03);
      wr(CT, 32'h2203);
      tick(1, 6);
      rc(CN, 32'h3);
      chk(timer_output_pin, 1'h1);
      rc(ST, 32'h40);
      chk(timer_irq, 1'h0);
      wr(tmh_pkg::ADDR_INT_ENABLE, 32'h40);
      rc(ST, 32'h40);
      chk(timer_irq, 1'h1);
      wr(CL, 32'h40);
      rc(ST, 32'h0);
      chk(timer_irq, 1'h0);
      wr(SE, 32'h4000);
      wr(CL, 32'h0);
      rc(ST, 32'h4000);
      chk(timer_irq, 1'h0);
      wr(SE, 32'hffff_ffff);
      rc(ST, 32'hffff);
      chk(timer_irq, 1'h1);
      wr(CL, 32'hffff);
      wr(CT, 32'h3e83);
      wr(CT, 32'h3683);
      tick(1, 4);
      chk(timer_output_pin, 1'h0);
      tick(1, 4);
      chk(timer_output_pin, 1'h1);
      rc(ST, 32'h4040);
      wr(CL, 32'hffff);
      wr(CT, 32'h2843);
      wr(CT, 32'h2043);
      tick(1, 4);
      chk(timer_output_pin, 1'h1);
      tick(1, 3);
      chk(timer_output_pin, 1'h0);
      rc(ST, 32'h0);
      wr(CT, 32'h28c3);
      wr(CT, 32'h20c3);
      tick(1, 4);
      chk(timer_output_pin, 1'h1);
      tick(1, 2);
      chk(timer_output_pin, 1'h0);
      tick(1, 4);
      chk(timer_output_pin, 1'h1);
      wr(CT, 32'h1000);
      rc(CT, 32'h1000);
      chk(timer_output_pin, 1'h1);
      test_done();
   end
endmodule : tmh_timer_tb_top
`default_nettype wire
